// ==== bcl_commutation.sv ====
// Operation
// - Position latch follows the sensors and captures at once on change.
// - After a capture the latch holds for two PWM ticks, then reopens.
// - Each of the six drives has an interlock flop set when it turns on.
// - An interlock clears two PWM ticks after its drive turns off.
// - A set interlock inhibits the opposing driver of the same phase.
// - A driver turns on only after its opposite was off two PWM ticks.
// - A valid code enables exactly one low-side and one high-side drive.
// - Direction 1 maps 001,011,010,110,100,101 to B/A,C/A,C/B,A/B,A/C,B/C.
// - Direction 0 maps 101,100,110,010,011,001 to C/B,C/A,B/A,B/C,A/C,A/B.
// - Codes 000 and 111 turn every driver off in either direction.
// - Dead time separates a driver turning off from its opposite on.
// - A sensor change loads the latch, pulses speed, inhibits the latch.
module bcl_commutation (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       pwm_tick,
  input  wire logic       direction_sel,
  input  wire logic       position_sense_1,
  input  wire logic       position_sense_2,
  input  wire logic       position_sense_3,
  output logic            low_side_drive_phase_a,
  output logic            low_side_drive_phase_b,
  output logic            low_side_drive_phase_c,
  output logic            high_side_drive_phase_a_n,
  output logic            high_side_drive_phase_b_n,
  output logic            high_side_drive_phase_c_n,
  output logic            speed_pulse
);

  logic [2:0]        sense_sync;
  logic [2:0]        pos_r;
  logic [1:0]        blank_cnt_r;
  bcl_pkg::bcl_blank_e blank_r;
  logic              change;
  logic [2:0]        low_want;
  logic [2:0]        high_want;
  logic [2:0]        low_on_r;
  logic [2:0]        high_on_r;
  logic [2:0]        low_lock;
  logic [2:0]        high_lock;
  logic [2:0]        low_nxt;
  logic [2:0]        high_nxt;
  logic [2:0]        low_pin_on;
  logic [2:0]        high_pin_on;

  // ---------------------------------------------------------------
  // Sensor synchroniser
  // ---------------------------------------------------------------
  bcl_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({position_sense_3, position_sense_2, position_sense_1}),
    .dout    (sense_sync)
  );

  assign change = (sense_sync != pos_r);

  // ---------------------------------------------------------------
  // Position latch with blanking
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_r       <= bcl_pkg::POS_RST;
      blank_r     <= bcl_pkg::BCL_OPEN;
      blank_cnt_r <= bcl_pkg::CNT_RST;
    end else begin
      unique case (blank_r)
        bcl_pkg::BCL_OPEN: begin
          if (change) begin
            pos_r       <= sense_sync;
            blank_r     <= bcl_pkg::BCL_BLANKED;
            blank_cnt_r <= bcl_pkg::CNT_RST;
          end
        end
        bcl_pkg::BCL_BLANKED: begin
          if (pwm_tick) begin
            if (blank_cnt_r == 2'(bcl_pkg::BLANK_TICKS - 1)) begin
              blank_r     <= bcl_pkg::BCL_OPEN;
              blank_cnt_r <= bcl_pkg::CNT_RST;
            end else begin
              blank_cnt_r <= blank_cnt_r + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Speed pulse
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      speed_pulse <= 1'b0;
    end else begin
      speed_pulse <= (blank_r == bcl_pkg::BCL_BLANKED) ||
                     change;
    end
  end

  // ---------------------------------------------------------------
  // Commutation decode, {low, high} one-hot per phase
  // ---------------------------------------------------------------
  always_comb begin
    low_want  = bcl_pkg::LOW_OFF;
    high_want = bcl_pkg::LOW_OFF;
    if (direction_sel) begin
      unique case (pos_r)
        3'h4: begin low_want = bcl_pkg::PH_B; high_want = bcl_pkg::PH_A; end
        3'h6: begin low_want = bcl_pkg::PH_C; high_want = bcl_pkg::PH_A; end
        3'h2: begin low_want = bcl_pkg::PH_C; high_want = bcl_pkg::PH_B; end
        3'h3: begin low_want = bcl_pkg::PH_A; high_want = bcl_pkg::PH_B; end
        3'h1: begin low_want = bcl_pkg::PH_A; high_want = bcl_pkg::PH_C; end
        3'h5: begin low_want = bcl_pkg::PH_B; high_want = bcl_pkg::PH_C; end
        default: begin
          low_want  = bcl_pkg::LOW_OFF;
          high_want = bcl_pkg::LOW_OFF;
        end
      endcase
    end else begin
      unique case (pos_r)
        3'h5: begin low_want = bcl_pkg::PH_C; high_want = bcl_pkg::PH_B; end
        3'h1: begin low_want = bcl_pkg::PH_C; high_want = bcl_pkg::PH_A; end
        3'h3: begin low_want = bcl_pkg::PH_B; high_want = bcl_pkg::PH_A; end
        3'h2: begin low_want = bcl_pkg::PH_B; high_want = bcl_pkg::PH_C; end
        3'h6: begin low_want = bcl_pkg::PH_A; high_want = bcl_pkg::PH_C; end
        3'h4: begin low_want = bcl_pkg::PH_A; high_want = bcl_pkg::PH_B; end
        default: begin
          low_want  = bcl_pkg::LOW_OFF;
          high_want = bcl_pkg::LOW_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-drive interlocks, bit 0 is phase A
  // ---------------------------------------------------------------
  assign low_pin_on  = {low_side_drive_phase_c, low_side_drive_phase_b,
                        low_side_drive_phase_a};
  assign high_pin_on = ~{high_side_drive_phase_c_n, high_side_drive_phase_b_n,
                         high_side_drive_phase_a_n};

  for (genvar i = 0; i < 3; i++) begin : g_phase
    bcl_interlock u_low_lock (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pwm_tick (pwm_tick),
      .drive_on (low_pin_on[i]),
      .lock     (low_lock[i])
    );
    bcl_interlock u_high_lock (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pwm_tick (pwm_tick),
      .drive_on (high_pin_on[i]),
      .lock     (high_lock[i])
    );
    assign low_nxt[i]  = low_want[i] && !high_lock[i] &&
                         !high_on_r[i] && !high_pin_on[i];
    assign high_nxt[i] = high_want[i] && !low_lock[i] &&
                         !low_on_r[i] && !low_pin_on[i];
  end

  // ---------------------------------------------------------------
  // Drive registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_on_r  <= bcl_pkg::LOW_OFF;
      high_on_r <= bcl_pkg::LOW_OFF;
    end else begin
      low_on_r  <= low_nxt & ~high_nxt;
      high_on_r <= high_nxt & ~low_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_side_drive_phase_a    <= 1'b0;
      low_side_drive_phase_b    <= 1'b0;
      low_side_drive_phase_c    <= 1'b0;
      high_side_drive_phase_a_n <= 1'b1;
      high_side_drive_phase_b_n <= 1'b1;
      high_side_drive_phase_c_n <= 1'b1;
    end else begin
      low_side_drive_phase_a    <= low_on_r[0];
      low_side_drive_phase_b    <= low_on_r[1];
      low_side_drive_phase_c    <= low_on_r[2];
      high_side_drive_phase_a_n <= !high_on_r[0];
      high_side_drive_phase_b_n <= !high_on_r[1];
      high_side_drive_phase_c_n <= !high_on_r[2];
    end
  end

endmodule // bcl_commutation

// ==== bcl_pkg.sv ====
package bcl_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned BLANK_TICKS     = 2;
  localparam int unsigned INTERLOCK_TICKS = 2;
  localparam int unsigned TICK_CNT_W      = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] POS_RST   = 3'h0;
  localparam logic [2:0] LOW_OFF   = 3'h0;
  localparam logic [2:0] HIGH_OFF  = 3'h7;
  localparam logic [1:0] CNT_RST   = 2'h0;

  // ---------------------------------------------------------------
  // Phase one-hot codes, bit 0 is phase A
  // ---------------------------------------------------------------
  localparam logic [2:0] PH_A = 3'h1;
  localparam logic [2:0] PH_B = 3'h2;
  localparam logic [2:0] PH_C = 3'h4;

  typedef enum logic [0:0] {
    BCL_OPEN    = 1'b0,
    BCL_BLANKED = 1'b1
  } bcl_blank_e;

endpackage

// ==== bcl_sync.sv ====
module bcl_sync (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [2:0] din,
  output logic      [2:0] dout
);

  logic [2:0] meta_r;

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= bcl_pkg::POS_RST;
      dout   <= bcl_pkg::POS_RST;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // bcl_sync

// ==== bcl_interlock.sv ====
module bcl_interlock (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pwm_tick,
  input  wire logic drive_on,
  output logic      lock
);

  logic [1:0] off_cnt_r;

  // ---------------------------------------------------------------
  // Set on drive, clear two ticks after drive off
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock      <= 1'b0;
      off_cnt_r <= bcl_pkg::CNT_RST;
    end else if (drive_on) begin
      lock      <= 1'b1;
      off_cnt_r <= bcl_pkg::CNT_RST;
    end else if (lock && pwm_tick) begin
      if (off_cnt_r == 2'(bcl_pkg::INTERLOCK_TICKS - 1)) begin
        lock      <= 1'b0;
        off_cnt_r <= bcl_pkg::CNT_RST;
      end else begin
        off_cnt_r <= off_cnt_r + 2'h1;
      end
    end
  end

endmodule // bcl_interlock

// ==== bcl_monitor.sv ====
module bcl_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwm_tick,
  input wire logic direction_sel,
  input wire logic position_sense_1,
  input wire logic position_sense_2,
  input wire logic position_sense_3,
  input wire logic low_side_drive_phase_a,
  input wire logic low_side_drive_phase_b,
  input wire logic low_side_drive_phase_c,
  input wire logic high_side_drive_phase_a_n,
  input wire logic high_side_drive_phase_b_n,
  input wire logic high_side_drive_phase_c_n,
  input wire logic speed_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Drive checks
  // ----------------------------------------
  wire logic [2:0] lo = {low_side_drive_phase_c, low_side_drive_phase_b,
                         low_side_drive_phase_a};
  wire logic [2:0] hi = ~{high_side_drive_phase_c_n, high_side_drive_phase_b_n,
                          high_side_drive_phase_a_n};
  logic [1:0] off_h_r;
  logic [1:0] off_l_r;
  logic [1:0] blank_tk_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) begin
    if (rst) off_h_r <= 2'h2;
    else if (hi[0]) off_h_r <= 2'h0;
    else if (pwm_tick && off_h_r != 2'h2) off_h_r <= off_h_r + 2'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) off_l_r <= 2'h2;
    else if (lo[0]) off_l_r <= 2'h0;
    else if (pwm_tick && off_l_r != 2'h2) off_l_r <= off_l_r + 2'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !speed_pulse) blank_tk_r <= 2'h0;
    else if (pwm_tick && blank_tk_r != 2'h3) blank_tk_r <= blank_tk_r + 2'h1;
  end
  a_excl_a: assert property (!(lo[0] && hi[0]))
    else $error("phase a overlap");
  a_excl_b: assert property (!(lo[1] && hi[1]))
    else $error("phase b overlap");
  a_excl_c: assert property (!(lo[2] && hi[2]))
    else $error("phase c overlap");
  a_one_low: assert property ($onehot0(lo))
    else $error("several low drives");
  a_one_high: assert property ($onehot0(hi))
    else $error("several high drives");
  a_blank_span: assert property ($fell(speed_pulse) |->
    blank_tk_r >= 2'h2) else $error("blank span");
  a_dead_low_a: assert property ($rose(lo[0]) |-> off_h_r == 2'h2)
    else $error("low a without dead time");
  a_dead_high_a: assert property ($rose(hi[0]) |-> off_l_r == 2'h2)
    else $error("high a without dead time");
endmodule // bcl_monitor

// ==== bcl_hall_model.sv ====
module bcl_hall_model (
  input  wire logic [2:0] code,
  output logic            sense_1,
  output logic            sense_2,
  output logic            sense_3
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensor pins follow the code, sense_1 first
  assign {sense_1, sense_2, sense_3} = code;
endmodule // bcl_hall_model

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       pwm_tick = 1'b0;
  logic       dir_sel = 1'b1;
  logic [2:0] code = 3'h1;
  logic [2:0] tcnt = 3'h0;
  int         cyc = 0;
  int         errors = 0;
  int         compares = 0;
  logic       s1, s2, s3, la, lb, lc, ha, hb, hc, sp;
  wire logic [5:0] drv = {lc, lb, la, hc, hb, ha};
  // ----------------------------------------
  // Clock, tick, instances
  // ----------------------------------------
  initial forever #10 ref_clk = ~ref_clk;
  bcl_hall_model hall (.code(code), .sense_1(s1), .sense_2(s2), .sense_3(s3));
  bcl_commutation dut (.ref_clk(ref_clk), .rst(rst), .pwm_tick(pwm_tick),
    .direction_sel(dir_sel), .position_sense_1(s1), .position_sense_2(s2),
    .position_sense_3(s3), .low_side_drive_phase_a(la),
    .low_side_drive_phase_b(lb), .low_side_drive_phase_c(lc),
    .high_side_drive_phase_a_n(ha), .high_side_drive_phase_b_n(hb),
    .high_side_drive_phase_c_n(hc), .speed_pulse(sp));
  always @(posedge ref_clk) begin
    tcnt <= #2 tcnt + 3'h1;
    pwm_tick <= #2 (tcnt == 3'h6);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      conclude;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [5:0] e, input logic [5:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp=%h got=%h", what, e, g);
    end
  endtask
  function automatic logic [5:0] exp_drv(input logic d, input logic [2:0] c);
    logic [5:0] p;
    case (c)
      3'h1: p = 6'h11;
      3'h3: p = 6'h21;
      3'h2: p = 6'h22;
      3'h6: p = 6'h0A;
      3'h4: p = 6'h0C;
      3'h5: p = 6'h14;
      default: p = 6'h00;
    endcase
    if (!d) p = {p[2:0], p[5:3]};
    return {p[5:3], ~p[2:0]};
  endfunction
  task automatic step(input logic d, input logic [2:0] c);
    @(posedge ref_clk);
    #2 dir_sel = d;
    code = c;
    repeat (40) @(posedge ref_clk);
    #2 chk("drive", exp_drv(d, c), drv);
  endtask
  task automatic t_table;
    logic [2:0] sq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    for (int i = 0; i < 6; i++) step(1'b1, sq[i]);
    for (int i = 5; i >= 0; i--) step(1'b0, sq[i]);
    step(1'b0, 3'h0);
    step(1'b1, 3'h7);
    step(1'b1, 3'h0);
    step(1'b0, 3'h7);
    $display("t_table done");
  endtask
  task automatic t_blank;
    step(1'b1, 3'h1);
    @(posedge ref_clk);
    #2 code = 3'h3;
    repeat (4) @(posedge ref_clk);
    #2 code = 3'h2;
    repeat (2) @(posedge ref_clk);
    #2 chk("speed", 6'h01, {5'h00, sp});
    chk("blank hold", exp_drv(1'b1, 3'h3), drv);
    repeat (50) @(posedge ref_clk);
    #2 chk("reopen", exp_drv(1'b1, 3'h2), drv);
    $display("t_blank done");
  endtask
  task automatic t_reverse;
    step(1'b1, 3'h1);
    @(posedge ref_clk);
    #2 dir_sel = 1'b0;
    repeat (5) @(posedge ref_clk);
    #2 chk("dead time", 6'h07, drv);
    repeat (40) @(posedge ref_clk);
    #2 chk("reversed", exp_drv(1'b0, 3'h1), drv);
    $display("t_reverse done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #2 rst = 1'b0;
    t_table;
    t_blank;
    t_reverse;
    conclude;
  end
endmodule // tb_top
bind bcl_commutation bcl_monitor u_mon (.*);
